//--- hdl/tcu_pkg.sv
// package for the timer control and update logic
package tcu_pkg;
  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_WAVEFORM_CONFIG_REGISTER = 4'h1;
  localparam logic [3:0] IDX_OVR = 4'h2;
  localparam logic [3:0] IDX_SPLIT = 4'h3;
  localparam logic [3:0] IDX_ECLR = 4'h4;
  localparam logic [3:0] IDX_ESET = 4'h5;
  localparam logic [3:0] IDX_FCLR = 4'h6;
  localparam logic [3:0] IDX_FSET = 4'h7;
  localparam logic [3:0] IDX_CTRLA = 4'h8;
  localparam logic [3:0] IDX_BUFWR = 4'h9;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W = 6;
  // field positions
  localparam int E_DIR = 0;
  localparam int E_LOCK = 1;
  localparam int E_CMD_LO = 2;
  localparam int F_PER = 0;
  localparam int F_CMP0 = 1;
  localparam int B_AUTO_LOCK_TRANSFER = 3;
  localparam int B_CMPEN0 = 4;
  localparam int SPLIT_BIT = 0;
  localparam int ENABLE_BIT = 0;
  localparam int NCH = 3;
  // reset values
  localparam logic [7:0] RST_8 = 8'h00;
  // command codes
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_UPDATE = 2'h1;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_HARDRST = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic update;
    logic restart;
    logic hard_reset;
    logic transfer;
  } tcu_cmd_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [ADDR_W-1:0] addr;
  } tcu_req_t;
endpackage

//--- hdl/tcu_reg8.sv
// one W-bit control register (1 to 32 bits, default 8) with set, clear and load ports
`timescale 1ns/1ps
module tcu_reg8
  import tcu_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);
  initial
  begin
    if (W < 1 || W > 32)
    begin
      $error("tcu_reg8 width out of range");
    end
  end

  logic [W-1:0] next_q;
  // set wins over clear so a hardware event is never lost
  assign next_q = ((load_i ? load_val_i : q_o) & ~clr_i) | set_i;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q_o <= RST;
    else
      q_o <= next_q;
  end
endmodule

//--- hdl/tcu_ctrl.sv
// timer control: output override, split select, commands, lock, direction, buffer valid
`timescale 1ns/1ps
// Contract
// RULE1: while disabled, override bits drive the waveform generator outputs directly.
// RULE2: pin sees override only with pin enable; logic block path ignores enable.
// RULE3: split mode bit selects two independent 8-bit timers.
// RULE4: command write: 1 update, 2 restart, 3 hard reset, 0 nothing.
// RULE5: hard reset command ignored while the timer is enabled.
// RULE6: command field always reads zero.
// RULE7: lock clear: buffers transfer on every UPDATE condition.
// RULE8: lock set: UPDATE transfers blocked, command update still transfers.
// RULE9: direction 0 up, 1 down; hardware and software both change it.
// RULE10: writing one to clear alias clears lock or direction bit.
// RULE11: writing one to set alias sets lock or direction bit.
// RULE12: compare valid sets on compare buffer write, clears on UPDATE.
// RULE13: period valid sets on period buffer write, clears on UPDATE.
// RULE14: valid flags via clear and set aliases; period bit0, compares bits1-3.
// RULE15: auto-lock holds lock until enabled compares valid, relocks after transfer.
// RULE16: in frequency and PWM modes pin shows output only with pin enable.
// RULE17: reads of either alias return shared bits, command read as zero.
module tcu_ctrl
  import tcu_pkg::*;
#(
  parameter int NUM_CH = NCH
)
(
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic UPDATE_COND_I,
  input wire logic WFM_PWM_FRQ_I,
  input wire logic HW_DIR_VALID_I,
  input wire logic HW_DIR_I,
  input wire logic [NUM_CH-1:0] WG_I,
  input wire logic PER_BUF_WR_I,
  input wire logic [NUM_CH-1:0] CMP_BUF_WR_I,
  output logic ENABLE_O,
  output logic SPLIT_MODE_O,
  output logic DIR_O,
  output logic LOCK_O,
  output logic TRANSFER_O,
  output logic RESTART_O,
  output logic HARD_RESET_O,
  output logic [NUM_CH-1:0] WG_OUT_O,
  output logic [NUM_CH-1:0] PIN_OUT_O,
  output logic [NUM_CH-1:0] CLB_OUT_O,
  output logic [NUM_CH:0] BUF_VALID_O
);
  initial
  begin
    if (NUM_CH != NCH)
    begin
      $error("tcu_ctrl supports exactly three compare channels");
    end
  end

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  tcu_req_t req;
  logic [3:0] req_idx;
  logic [7:0] wbyte;
  logic take;
  logic we;
  logic [7:0] rd;

  assign take = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ);
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign req_idx = req.addr[ADDR_LSB+3:ADDR_LSB];
  assign wbyte = HWDATA_I[7:0];
  assign we = req.sel && req.write;

  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      req <= '0;
    else
      req <= take ? '{sel: 1'b1, write: HWRITE_I, addr: HADDR_I[ADDR_W-1:0]} : '0;
  end

  logic wr_ctrla;
  logic wr_waveform_config_register;
  logic wr_ovr;
  logic wr_split;
  logic wr_eclr;
  logic wr_eset;
  logic wr_fclr;
  logic wr_fset;
  logic wr_bufwr;
  assign wr_ctrla = we && (req_idx == IDX_CTRLA);
  assign wr_waveform_config_register = we && (req_idx == IDX_WAVEFORM_CONFIG_REGISTER);
  assign wr_ovr = we && (req_idx == IDX_OVR);
  assign wr_split = we && (req_idx == IDX_SPLIT);
  assign wr_eclr = we && (req_idx == IDX_ECLR);
  assign wr_eset = we && (req_idx == IDX_ESET);
  assign wr_fclr = we && (req_idx == IDX_FCLR);
  assign wr_fset = we && (req_idx == IDX_FSET);
  assign wr_bufwr = we && (req_idx == IDX_BUFWR);

  // ------------------------------------------------------------
  // plain control registers
  // ------------------------------------------------------------
  logic [7:0] ctrla;
  logic [7:0] waveform_config_register;
  logic [7:0] ovr;
  logic [7:0] split;

  tcu_reg8 #(.W(8), .RST(RST_8)) u_ctrla (.clk_i(MCLK_I), .rstn_i(RSTN_I),
    .load_i(wr_ctrla), .load_val_i(wbyte & 8'h01), .set_i(8'h00), .clr_i(8'h00),
    .q_o(ctrla));
  tcu_reg8 #(.W(8), .RST(RST_8)) u_waveform_config_register (.clk_i(MCLK_I), .rstn_i(RSTN_I),
    .load_i(wr_waveform_config_register), .load_val_i(wbyte & 8'h78), .set_i(8'h00), .clr_i(8'h00),
    .q_o(waveform_config_register));
  tcu_reg8 #(.W(8), .RST(RST_8)) u_ovr (.clk_i(MCLK_I), .rstn_i(RSTN_I),
    .load_i(wr_ovr), .load_val_i(wbyte & 8'h07), .set_i(8'h00), .clr_i(8'h00),
    .q_o(ovr));
  tcu_reg8 #(.W(8), .RST(RST_8)) u_split (.clk_i(MCLK_I), .rstn_i(RSTN_I),
    .load_i(wr_split), .load_val_i(wbyte & 8'h01), .set_i(8'h00), .clr_i(8'h00),
    .q_o(split));

  logic enabled;
  logic auto_lock_transfer;
  logic [NUM_CH-1:0] cmp_en;
  assign enabled = ctrla[ENABLE_BIT];
  assign auto_lock_transfer = waveform_config_register[B_AUTO_LOCK_TRANSFER];
  assign cmp_en = waveform_config_register[B_CMPEN0 +: NUM_CH];
  assign ENABLE_O = enabled;
  assign SPLIT_MODE_O = split[SPLIT_BIT]; // RULE3

  // ------------------------------------------------------------
  // commands
  // ------------------------------------------------------------
  logic [1:0] cmd_wr;
  logic cmd_strobe;
  tcu_cmd_t next_cmd;
  tcu_cmd_t cmd;
  logic auto_update;
  logic lock;

  assign cmd_strobe = wr_eclr || wr_eset;
  assign cmd_wr = cmd_strobe ? wbyte[E_CMD_LO +: 2] : CMD_NONE;
  assign next_cmd.update = (cmd_wr == CMD_UPDATE); // RULE4
  assign next_cmd.restart = (cmd_wr == CMD_RESTART); // RULE4
  assign next_cmd.hard_reset = (cmd_wr == CMD_HARDRST) && !enabled; // RULE5
  // lock only blocks UPDATE-condition transfers, not the command
  assign auto_update = UPDATE_COND_I && !lock; // RULE7 RULE8
  assign next_cmd.transfer = auto_update || next_cmd.update; // RULE8

  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      cmd <= '0;
    else
      cmd <= next_cmd;
  end

  assign TRANSFER_O = cmd.transfer;
  assign RESTART_O = cmd.restart;
  assign HARD_RESET_O = cmd.hard_reset;

  // ------------------------------------------------------------
  // lock and direction
  // ------------------------------------------------------------
  logic dir;
  logic all_valid;
  logic lock_set;
  logic lock_clr;
  logic dir_set;
  logic dir_clr;
  logic [NUM_CH:0] bv;

  assign all_valid = &(bv[F_CMP0 +: NUM_CH] | ~cmp_en);
  // auto-lock: flags still read valid in the transfer cycle, so relock on the pulse itself
  assign lock_clr = (wr_eclr && wbyte[E_LOCK]) || (auto_lock_transfer && all_valid); // RULE10 RULE15
  assign lock_set = (wr_eset && wbyte[E_LOCK])
    || (auto_lock_transfer && (cmd.transfer || !all_valid)); // RULE11 RULE15
  assign dir_clr = (wr_eclr && wbyte[E_DIR]) || (HW_DIR_VALID_I && !HW_DIR_I); // RULE9 RULE10
  assign dir_set = (wr_eset && wbyte[E_DIR]) || (HW_DIR_VALID_I && HW_DIR_I); // RULE9 RULE11

  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      lock <= 1'b0;
      dir <= 1'b0;
    end
    else
    begin
      lock <= lock_set | (lock & ~lock_clr);
      dir <= dir_set | (dir & ~dir_clr);
    end
  end

  assign LOCK_O = lock;
  assign DIR_O = dir; // RULE9

  // ------------------------------------------------------------
  // buffer valid flags
  // ------------------------------------------------------------
  logic [NUM_CH:0] bv_set;
  logic [NUM_CH:0] bv_clr;
  logic [NUM_CH:0] buf_wr;

  // buffer-write register stands in for the core's strobes when driven by software
  assign buf_wr = {CMP_BUF_WR_I, PER_BUF_WR_I} | (wr_bufwr ? wbyte[NUM_CH:0] : '0);

  generate
    for (genvar i = 0; i <= NUM_CH; i++)
    begin : g_bv
      // set wins: a buffer write in the transfer cycle stays valid
      assign bv_set[i] = buf_wr[i] || (wr_fset && wbyte[i]); // RULE12 RULE13 RULE14
      assign bv_clr[i] = cmd.transfer || (wr_fclr && wbyte[i]); // RULE12 RULE13 RULE14
    end
  endgenerate

  tcu_reg8 #(.W(NUM_CH + 1), .RST('0)) u_bv (.clk_i(MCLK_I), .rstn_i(RSTN_I),
    .load_i(1'b0), .load_val_i('0), .set_i(bv_set), .clr_i(bv_clr), .q_o(bv));
  assign BUF_VALID_O = bv;

  // ------------------------------------------------------------
  // waveform outputs
  // ------------------------------------------------------------
  logic [NUM_CH-1:0] next_wg;
  logic [NUM_CH-1:0] next_pin;

  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_wg
      assign next_wg[c] = enabled ? WG_I[c] : ovr[c]; // RULE1
      // pin drive only in frequency and PWM modes, or when stopped for override
      assign next_pin[c] = cmp_en[c] && (!enabled || WFM_PWM_FRQ_I) && next_wg[c]; // RULE2 RULE16
    end
  endgenerate

  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      WG_OUT_O <= '0;
      PIN_OUT_O <= '0;
      CLB_OUT_O <= '0;
    end
    else
    begin
      WG_OUT_O <= next_wg;
      PIN_OUT_O <= next_pin;
      CLB_OUT_O <= next_wg; // RULE2
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [7:0] e_view;
  logic [3:0] rd_idx;
  assign e_view = {6'b0, lock, dir}; // RULE6 RULE17
  // read index from the address phase, data registered for the data phase
  assign rd_idx = HADDR_I[ADDR_LSB+3:ADDR_LSB];

  always_comb
  begin
    case (rd_idx)
      IDX_CTRLA: rd = ctrla;
      IDX_WAVEFORM_CONFIG_REGISTER: rd = waveform_config_register;
      IDX_OVR: rd = ovr;
      IDX_SPLIT: rd = split;
      IDX_ECLR: rd = e_view;
      IDX_ESET: rd = e_view;
      IDX_FCLR: rd = {4'b0, bv};
      IDX_FSET: rd = {4'b0, bv};
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      HRDATA_O <= '0;
    else
      HRDATA_O <= take && !HWRITE_I ? {24'h0, rd} : HRDATA_O;
  end
endmodule

//--- test/tcu_ctrl_monitor.sv
// port checker for the timer control block
`timescale 1ns/1ps
module tcu_ctrl_monitor
  import tcu_pkg::*;
#(
  parameter int NUM_CH = NCH
)
(
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic UPDATE_COND_I,
  input wire logic HW_DIR_VALID_I,
  input wire logic HW_DIR_I,
  input wire logic [NUM_CH-1:0] WG_I,
  input wire logic PER_BUF_WR_I,
  input wire logic [NUM_CH-1:0] CMP_BUF_WR_I,
  input wire logic ENABLE_O,
  input wire logic DIR_O,
  input wire logic LOCK_O,
  input wire logic TRANSFER_O,
  input wire logic HARD_RESET_O,
  input wire logic [NUM_CH-1:0] WG_OUT_O,
  input wire logic [NUM_CH-1:0] PIN_OUT_O,
  input wire logic [NUM_CH-1:0] CLB_OUT_O,
  input wire logic [NUM_CH:0] BUF_VALID_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);
  // update taken only while unlocked, then the flags must drop
  sequence s_upd_taken;
    UPDATE_COND_I && !LOCK_O ##1 TRANSFER_O;
  endsequence
  chk_bus_okay: assert property (HREADYOUT_O && !HRESP_O && HRDATA_O[31:8] == '0)
    else $error("bus answer not okay");
  chk_wg_follow: assert property (ENABLE_O |=> WG_OUT_O == $past(WG_I))
    else $error("waveform output does not follow generator");
  chk_pin_gated: assert property ((PIN_OUT_O & ~CLB_OUT_O) == '0)
    else $error("pin high while ungated path low");
  chk_hardrst_gated: assert property ($rose(HARD_RESET_O) |-> !$past(ENABLE_O))
    else $error("hard reset while enabled");
  chk_upd_transfer: assert property (UPDATE_COND_I && !LOCK_O |=> TRANSFER_O)
    else $error("unlocked update gave no transfer");
  chk_upd_locked: assert property (UPDATE_COND_I && LOCK_O |=> !TRANSFER_O)
    else $error("locked update transferred");
  chk_dir_hw: assert property (HW_DIR_VALID_I |=> DIR_O == $past(HW_DIR_I))
    else $error("hardware direction not taken");
  chk_valid_drop: assert property (s_upd_taken |-> ##[0:1] BUF_VALID_O == '0)
    else $error("valid flags kept after update");
  chk_per_valid: assert property (PER_BUF_WR_I && !UPDATE_COND_I |-> ##[1:2] BUF_VALID_O[F_PER])
    else $error("period valid not set");
  chk_cmp_valid: assert property (CMP_BUF_WR_I[0] && !UPDATE_COND_I |-> ##[1:2] BUF_VALID_O[F_CMP0])
    else $error("compare valid not set");
endmodule

//--- test/timer_control_update_logic_tb_top.sv
// self-checking bench for the timer control block
`timescale 1ns/1ps
module timer_control_update_logic_tb_top;
  import tcu_pkg::*;
  typedef struct packed {
    logic port;
    logic [19:0] val;
  } tcu_note_t;
  localparam logic [7:0] CDAT [4] = '{8'h0C, 8'h02, 8'h06, 8'h0A};
  localparam logic [10:0] CEXP [4] = '{11'h200, 11'h040, 11'h140, 11'h440};
  logic mclk, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, wg, wgv, wg_out, pin_out, clb_out, cmp_wr;
  logic upd, pwm, hwv, hwd, per_wr, en, split, dir, lock, tr, rs, hr, rvalid, pvalid;
  logic [3:0] bv;
  logic [19:0] obs, got;
  tcu_note_t q[$];
  tcu_note_t n;
  int fail_count = 0;
  int checks = 0;
  assign obs = {pin_out, clb_out, wg_out, rs, hr, tr, split, lock, dir, en, bv};
  assign hready = hreadyout;
  tcu_ctrl u_dut (
    .MCLK_I(mclk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .UPDATE_COND_I(upd), .WFM_PWM_FRQ_I(pwm), .HW_DIR_VALID_I(hwv), .HW_DIR_I(hwd),
    .WG_I(wg), .PER_BUF_WR_I(per_wr), .CMP_BUF_WR_I(cmp_wr), .ENABLE_O(en),
    .SPLIT_MODE_O(split), .DIR_O(dir), .LOCK_O(lock), .TRANSFER_O(tr),
    .RESTART_O(rs), .HARD_RESET_O(hr), .WG_OUT_O(wg_out), .PIN_OUT_O(pin_out),
    .CLB_OUT_O(clb_out), .BUF_VALID_O(bv)
  );
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------
  // bus and strobe drivers
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = $urandom();
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {26'h0, a, 2'h0};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {r[31:8], d};
    rvalid <= ~w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rvalid <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    q.push_back({1'b0, 12'h0, e});
    xfer(1'b0, a, 8'h00);
  endtask
  task automatic pk(input logic [19:0] e);
    q.push_back({1'b1, e});
    pvalid <= 1'b1;
    @(posedge mclk);
    pvalid <= 1'b0;
  endtask
  // one cycle of {update, hw direction, period write, compare writes}
  task automatic strobe(input logic [5:0] s);
    {upd, hwv, per_wr, cmp_wr} <= s;
    @(posedge mclk);
    {upd, hwv, per_wr, cmp_wr} <= 6'h00;
  endtask
  task automatic conclude;
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk)
    if (rvalid || pvalid)
    begin
      n = q.pop_front();
      got = n.port ? obs : {12'h0, hrdata[7:0]};
      checks++;
      if (got !== n.val)
      begin
        fail_count++;
        $display("MISMATCH %0t got %h expected %h", $time, got, n.val);
      end
    end
  initial
  begin
    repeat (2000) @(posedge mclk);
    fail_count++;
    conclude();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    wgv = 3'($urandom(24));
    wg = wgv;
    {rstn, hsel, hwrite, upd, hwv, per_wr, rvalid, pvalid} = 8'h00;
    {htrans, haddr, hwdata, cmp_wr} = '0;
    {pwm, hwd} = 2'h3;
    hsize = HSIZE_WORD;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    hsel <= 1'b1;
    for (int i = 1; i < 8; i++)
      rd(4'(i), RST_8);
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_ESET, CDAT[i]);
      pk({9'h0, CEXP[i]});
    end
    rd(IDX_ECLR, 8'h02);
    rd(IDX_ESET, 8'h02);
    wr(IDX_ESET, 8'h01);
    rd(IDX_ECLR, 8'h03);
    wr(IDX_ECLR, 8'h01);
    rd(IDX_ESET, 8'h02);
    strobe(6'h10);
    pk(20'h00060);
    strobe(6'h20);
    pk(20'h00060);
    strobe(6'h0D);
    rd(IDX_FSET, 8'h0B);
    wr(IDX_FCLR, 8'h02);
    rd(IDX_FCLR, 8'h09);
    wr(IDX_FSET, 8'h04);
    rd(IDX_FSET, 8'h0D);
    wr(IDX_ECLR, 8'h02);
    strobe(6'h20);
    @(posedge mclk);
    rd(IDX_FSET, 8'h00);
    wr(IDX_CTRLA, 8'h01);
    wr(IDX_ESET, 8'h0C);
    pk({3'h0, wgv, wgv, 7'h03, 4'h0});
    wr(IDX_CTRLA, 8'h00);
    wr(IDX_OVR, 8'h03);
    wr(IDX_WAVEFORM_CONFIG_REGISTER, 8'h50);
    @(posedge mclk);
    pk({3'h1, 3'h3, 3'h3, 7'h02, 4'h0});
    rd(IDX_WAVEFORM_CONFIG_REGISTER, 8'h50);
    rd(4'hF, 8'h00);
    wr(IDX_SPLIT, 8'h01);
    pk({3'h1, 3'h3, 3'h3, 7'h0A, 4'h0});
    repeat (2) @(posedge mclk);
    conclude();
  end
endmodule

bind tcu_ctrl tcu_ctrl_monitor #(.NUM_CH(NUM_CH)) u_mon (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .UPDATE_COND_I(UPDATE_COND_I), .HW_DIR_VALID_I(HW_DIR_VALID_I),
  .HW_DIR_I(HW_DIR_I), .WG_I(WG_I), .PER_BUF_WR_I(PER_BUF_WR_I),
  .CMP_BUF_WR_I(CMP_BUF_WR_I), .ENABLE_O(ENABLE_O), .DIR_O(DIR_O), .LOCK_O(LOCK_O),
  .TRANSFER_O(TRANSFER_O), .HARD_RESET_O(HARD_RESET_O), .WG_OUT_O(WG_OUT_O),
  .PIN_OUT_O(PIN_OUT_O), .CLB_OUT_O(CLB_OUT_O), .BUF_VALID_O(BUF_VALID_O)
);
